// ### common/wic_pkg.sv
`default_nettype none
package wic_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VEC_W = 12;
  localparam int NUM_SRC = 4;
  // register byte addresses
  localparam logic [7:0] ADDR_IRQ_MASK_BANK = 8'h00;
  localparam logic [7:0] ADDR_WAKEUP_CTL_BANK = 8'h04;
  localparam logic [7:0] ADDR_AUX_IRQ_ENABLE_BANK = 8'h08;
  localparam logic [7:0] ADDR_IRQ_FLAG_BANK = 8'h0C;
  localparam logic [7:0] ADDR_ADC_CTL_WORD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // source index, also flag bit position in irq_flag_bank
  localparam int SRC_TICK = 0;
  localparam int SRC_PIN_CHANGE = 1;
  localparam int SRC_EXT_PIN = 2;
  localparam int SRC_CONV_DONE = 3;
  // enable and control bit positions
  localparam int BIT_TICK_OVF_IRQ_EN = 0;
  localparam int BIT_PIN_CHANGE_IRQ_EN = 1;
  localparam int BIT_EXT_PIN_IRQ_EN = 2;
  localparam int BIT_PIN_CHANGE_WAKE_EN = 1;
  localparam int BIT_CONV_DONE_WAKE_EN = 3;
  localparam int BIT_CONV_DONE_IRQ_EN = 5;
  localparam int BIT_CONV_ACTIVE = 0;
  // status bits
  localparam int BIT_ST_SLEEP = 0;
  localparam int BIT_ST_UNMASK = 1;
  localparam int BIT_ST_REQ = 2;
  localparam int BIT_ST_CLK_RUN = 3;
  localparam int BIT_ST_VEC_LO = 8;
  localparam logic [7:0] RESET_BANK = 8'h00;
  // interrupt vectors
  localparam logic [VEC_W-1:0] VEC_EXT_PIN = 12'h003;
  localparam logic [VEC_W-1:0] VEC_PIN_CHANGE = 12'h006;
  localparam logic [VEC_W-1:0] VEC_TICK = 12'h009;
  localparam logic [VEC_W-1:0] VEC_CONV_DONE = 12'h00C;
  localparam logic [VEC_W-1:0] VEC_NONE = 12'h000;
  // wake from conversion takes this many converter clock periods
  localparam logic [3:0] WAKE_TAD_COUNT = 4'hF;
  localparam int PORT_W = 8;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE_DLY} wic_state_t;
endpackage : wic_pkg
`default_nettype wire

// ### core/wic_pin_sync.sv
`default_nettype none
module wic_pin_sync
  import wic_pkg::*;
#(
  parameter int W = 1
)(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] pin_in,
  output logic chg_out,
  output logic fall_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;
  logic [W-1:0] prev_nxt;

  always_comb
  begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // change and falling edge seen after the second stage only
  assign chg_out = |(sync_r ^ prev_r);
  assign fall_out = |(prev_r & ~sync_r);
endmodule // wic_pin_sync
`default_nettype wire

// ### core/wic_top.sv
`default_nettype none
module wic_top
  import wic_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  output logic [DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ext_pin_in,
  input wire logic [PORT_W-1:0] port_pins_in,
  input wire logic tick_ovf_in,
  input wire logic conv_done_in,
  input wire logic tad_tick_in,
  input wire logic global_irq_unmask_op_in,
  input wire logic global_irq_mask_op_in,
  input wire logic sleep_op_in,
  input wire logic irq_ack_in,
  output logic irq_req_out,
  output logic [VEC_W-1:0] irq_vector_out,
  output logic wake_out,
  output logic sleep_out,
  output logic clocks_run_out,
  output logic conv_active_out
);
  function automatic logic [VEC_W-1:0] pri_vec(input logic [NUM_SRC-1:0] p);
    if (p[SRC_EXT_PIN])
      return VEC_EXT_PIN;
    else if (p[SRC_PIN_CHANGE])
      return VEC_PIN_CHANGE;
    else if (p[SRC_TICK])
      return VEC_TICK;
    else if (p[SRC_CONV_DONE])
      return VEC_CONV_DONE;
    else
      return VEC_NONE;
  endfunction

  logic ext_ev;
  logic pc_ev;
  wic_pin_sync #(.W(1)) u_ext_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(ext_pin_in),
    .chg_out(),
    .fall_out(ext_ev)
  );
  wic_pin_sync #(.W(PORT_W)) u_port_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(port_pins_in),
    .chg_out(pc_ev),
    .fall_out()
  );

  // bus slave: one wait cycle, then answer
  logic [7:0] irq_mask_bank_r, irq_mask_bank_nxt;
  logic [7:0] wakeup_ctl_bank_r, wakeup_ctl_bank_nxt;
  logic [7:0] aux_irq_enable_bank_r, aux_irq_enable_bank_nxt;
  logic [NUM_SRC-1:0] irq_flag_bank_r, irq_flag_bank_nxt;
  logic conv_active_r, conv_active_nxt;
  logic wait_r, wait_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic wr_commit;
  logic [DATA_W-1:0] status_word;

  logic unmask_r, unmask_nxt;
  wic_state_t state_r, state_nxt;
  logic [3:0] tad_cnt_r, tad_cnt_nxt;
  logic irq_req_r, irq_req_nxt;
  logic [VEC_W-1:0] vec_r, vec_nxt;
  logic wake_r, wake_nxt;
  logic sleep_r, sleep_nxt;
  logic clk_run_r, clk_run_nxt;

  logic pc_wake_en, conv_wake_en, conv_irq_en;
  logic [NUM_SRC-1:0] src_en, src_set, pend;
  logic tick_ev, sleep_entry, conv_wake_done;

  assign pc_wake_en = wakeup_ctl_bank_r[BIT_PIN_CHANGE_WAKE_EN];
  assign conv_wake_en = wakeup_ctl_bank_r[BIT_CONV_DONE_WAKE_EN];
  assign conv_irq_en = aux_irq_enable_bank_r[BIT_CONV_DONE_IRQ_EN];
  assign src_en = {conv_irq_en, irq_mask_bank_r[BIT_EXT_PIN_IRQ_EN],
                   irq_mask_bank_r[BIT_PIN_CHANGE_IRQ_EN], irq_mask_bank_r[BIT_TICK_OVF_IRQ_EN]};
  // timer stands still while the clocks are halted
  assign tick_ev = tick_ovf_in && clk_run_r;
  assign sleep_entry = sleep_op_in && (state_r == ST_RUN);
  assign wr_commit = avs_write_in && !wait_r;
  assign pend = irq_flag_bank_r & src_en;
  assign conv_wake_done = (state_r == ST_WAKE_DLY) && tad_tick_in
                          && (tad_cnt_r == WAKE_TAD_COUNT - 4'h1);

  always_comb
  begin
    status_word = '0;
    status_word[BIT_ST_SLEEP] = sleep_r;
    status_word[BIT_ST_UNMASK] = unmask_r;
    status_word[BIT_ST_REQ] = irq_req_r;
    status_word[BIT_ST_CLK_RUN] = clk_run_r;
    status_word[BIT_ST_VEC_LO +: VEC_W] = vec_r;
  end

  always_comb
  begin
    wait_nxt = !((avs_read_in || avs_write_in) && wait_r);
    rdata_nxt = rdata_r;
    if ((avs_read_in || avs_write_in) && wait_r)
    begin
      rdata_nxt = '0;
      case (avs_address_in)
        ADDR_IRQ_MASK_BANK: rdata_nxt[7:0] = irq_mask_bank_r;
        ADDR_WAKEUP_CTL_BANK: rdata_nxt[7:0] = wakeup_ctl_bank_r;
        ADDR_AUX_IRQ_ENABLE_BANK: rdata_nxt[7:0] = aux_irq_enable_bank_r;
        ADDR_IRQ_FLAG_BANK: rdata_nxt[NUM_SRC-1:0] = irq_flag_bank_r;
        ADDR_ADC_CTL_WORD: rdata_nxt[BIT_CONV_ACTIVE] = conv_active_r;
        ADDR_STATUS: rdata_nxt = status_word;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // configuration and flags
  always_comb
  begin
    irq_mask_bank_nxt = irq_mask_bank_r;
    wakeup_ctl_bank_nxt = wakeup_ctl_bank_r;
    aux_irq_enable_bank_nxt = aux_irq_enable_bank_r;
    conv_active_nxt = conv_active_r;
    src_set = '0;
    if (wr_commit && avs_address_in == ADDR_IRQ_MASK_BANK)
      irq_mask_bank_nxt = avs_writedata_in[7:0];
    if (wr_commit && avs_address_in == ADDR_WAKEUP_CTL_BANK)
      wakeup_ctl_bank_nxt = avs_writedata_in[7:0];
    if (wr_commit && avs_address_in == ADDR_AUX_IRQ_ENABLE_BANK)
      aux_irq_enable_bank_nxt = avs_writedata_in[7:0];
    if (wr_commit && avs_address_in == ADDR_ADC_CTL_WORD)
      conv_active_nxt = avs_writedata_in[BIT_CONV_ACTIVE];
    src_set[SRC_EXT_PIN] = ext_ev && src_en[SRC_EXT_PIN];
    src_set[SRC_PIN_CHANGE] = pc_ev && src_en[SRC_PIN_CHANGE];
    src_set[SRC_TICK] = tick_ev && src_en[SRC_TICK];
    src_set[SRC_CONV_DONE] = conv_done_in && conv_irq_en;
    if (conv_done_in)
      conv_active_nxt = 1'b0;
    if (sleep_entry && !conv_wake_en)
    begin
      conv_active_nxt = 1'b0;
      if (conv_irq_en && conv_active_r)
        src_set[SRC_CONV_DONE] = 1'b1;
    end
    irq_flag_bank_nxt = irq_flag_bank_r;
    if (wr_commit && avs_address_in == ADDR_IRQ_FLAG_BANK)
      irq_flag_bank_nxt = irq_flag_bank_r & avs_writedata_in[NUM_SRC-1:0];
    irq_flag_bank_nxt = irq_flag_bank_nxt | src_set;
  end

  // sleep, wake and dispatch
  always_comb
  begin
    state_nxt = state_r;
    tad_cnt_nxt = tad_cnt_r;
    wake_nxt = 1'b0;
    unmask_nxt = unmask_r;
    irq_req_nxt = irq_req_r;
    vec_nxt = vec_r;
    if (global_irq_unmask_op_in)
      unmask_nxt = 1'b1;
    if (global_irq_mask_op_in)
      unmask_nxt = 1'b0;
    case (state_r)
      ST_RUN:
      begin
        if (sleep_op_in)
          state_nxt = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (pc_ev && pc_wake_en)
        begin
          state_nxt = ST_RUN;
          wake_nxt = 1'b1;
        end
        else if (conv_done_in && conv_wake_en)
        begin
          state_nxt = ST_WAKE_DLY;
          tad_cnt_nxt = '0;
        end
      end
      ST_WAKE_DLY:
      begin
        if (tad_tick_in)
          tad_cnt_nxt = tad_cnt_r + 4'h1;
        if (conv_wake_done)
        begin
          state_nxt = ST_RUN;
          wake_nxt = 1'b1;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
    if (irq_req_r)
    begin
      if (irq_ack_in)
      begin
        irq_req_nxt = 1'b0;
        unmask_nxt = 1'b0;
      end
    end
    else if (state_r == ST_RUN && !sleep_op_in && unmask_r && (|pend))
    begin
      irq_req_nxt = 1'b1;
      vec_nxt = pri_vec(pend);
    end
    sleep_nxt = (state_nxt != ST_RUN);
    clk_run_nxt = !sleep_nxt || conv_wake_en;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      irq_mask_bank_r <= RESET_BANK;
      wakeup_ctl_bank_r <= RESET_BANK;
      aux_irq_enable_bank_r <= RESET_BANK;
      irq_flag_bank_r <= '0;
      conv_active_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= '0;
      unmask_r <= 1'b0;
      state_r <= ST_RUN;
      tad_cnt_r <= '0;
      irq_req_r <= 1'b0;
      vec_r <= VEC_NONE;
      wake_r <= 1'b0;
      sleep_r <= 1'b0;
      clk_run_r <= 1'b1;
    end
    else
    begin
      irq_mask_bank_r <= irq_mask_bank_nxt;
      wakeup_ctl_bank_r <= wakeup_ctl_bank_nxt;
      aux_irq_enable_bank_r <= aux_irq_enable_bank_nxt;
      irq_flag_bank_r <= irq_flag_bank_nxt;
      conv_active_r <= conv_active_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      unmask_r <= unmask_nxt;
      state_r <= state_nxt;
      tad_cnt_r <= tad_cnt_nxt;
      irq_req_r <= irq_req_nxt;
      vec_r <= vec_nxt;
      wake_r <= wake_nxt;
      sleep_r <= sleep_nxt;
      clk_run_r <= clk_run_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign irq_req_out = irq_req_r;
  assign irq_vector_out = vec_r;
  assign wake_out = wake_r;
  assign sleep_out = sleep_r;
  assign clocks_run_out = clk_run_r;
  assign conv_active_out = conv_active_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic flag_clr_wr;
  assign flag_clr_wr = wr_commit && avs_address_in == ADDR_IRQ_FLAG_BANK;
  property p_ext_flag;
    ext_ev && src_en[SRC_EXT_PIN] |=> irq_flag_bank_r[SRC_EXT_PIN];
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("ext pin flag not set");

  property p_ext_vector;
    state_r == ST_RUN && !sleep_op_in && !irq_req_r && unmask_r && pend[SRC_EXT_PIN]
      |=> irq_req_r && vec_r == VEC_EXT_PIN;
  endproperty
  a_ext_vector: assert property (p_ext_vector)
    else $error("ext pin vector not raised");

  property p_sleep_halt;
    $rose(sleep_r) && !$past(conv_wake_en) |-> !clk_run_r;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt)
    else $error("clocks running in sleep");

  property p_pc_no_wake;
    state_r == ST_SLEEP && pc_ev && !pc_wake_en && src_en[SRC_PIN_CHANGE] && !conv_done_in
      |=> irq_flag_bank_r[SRC_PIN_CHANGE] && sleep_r && !wake_r;
  endproperty
  a_pc_no_wake: assert property (p_pc_no_wake)
    else $error("pin change woke without wake enable");

  property p_pc_wake;
    state_r == ST_SLEEP && pc_ev && pc_wake_en |=> wake_r && !sleep_r;
  endproperty
  a_pc_wake: assert property (p_pc_wake)
    else $error("pin change wake missing");

  property p_tick_flag;
    tick_ev && src_en[SRC_TICK] |=> irq_flag_bank_r[SRC_TICK];
  endproperty
  a_tick_flag: assert property (p_tick_flag)
    else $error("tick overflow flag not set");

  property p_conv_stop;
    sleep_entry && !conv_wake_en |=> !conv_active_r;
  endproperty
  a_conv_stop: assert property (p_conv_stop)
    else $error("converter not stopped at sleep");
  logic [4:0] tad_seen_r, tad_seen_nxt;
  always_comb
    tad_seen_nxt = (state_r == ST_WAKE_DLY) ? tad_seen_r + {4'h0, tad_tick_in} : 5'h00;
  always_ff @(posedge clk_in)
    tad_seen_r <= rst_b_in ? tad_seen_nxt : 5'h00;
  property p_conv_wake_delay;
    state_r == ST_WAKE_DLY && wake_nxt |-> tad_seen_nxt == {1'h0, WAKE_TAD_COUNT};
  endproperty
  a_conv_wake_delay: assert property (p_conv_wake_delay)
    else $error("conversion wake too early");
  property p_conv_wake_end;
    conv_wake_done |=> wake_r && !sleep_r;
  endproperty
  a_conv_wake_end: assert property (p_conv_wake_end)
    else $error("conversion wake not issued");

  property p_flag_hold;
    irq_flag_bank_r[SRC_CONV_DONE] && !flag_clr_wr |=> irq_flag_bank_r[SRC_CONV_DONE];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag lost without clear");

  property p_one_at_a_time;
    irq_req_r && !irq_ack_in |=> irq_req_r && $stable(vec_r);
  endproperty
  a_one_at_a_time: assert property (p_one_at_a_time)
    else $error("vector changed while pending");

  c_ext_vector: cover property (irq_req_r && vec_r == VEC_EXT_PIN);
  c_pc_wake: cover property ($rose(wake_r) && state_r == ST_RUN);
  c_conv_wake: cover property (conv_wake_done ##1 wake_r);
  c_two_pending: cover property (irq_req_r && $countones(pend) > 1);
endmodule // wic_top
`default_nettype wire

// ### sim/test_wakeup_interrupt_control.sv
`default_nettype none
module test_wakeup_interrupt_control
  import wic_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] src; logic en; logic unm; logic [VEC_W-1:0] vec;} wic_row_t;
  wic_row_t rows [12];
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wd = 32'h0;
  logic ext = 1'h1;
  logic [7:0] pins = 8'h00;
  logic tick = 1'h0;
  logic conv = 1'h0;
  logic tad = 1'h0;
  logic unm = 1'h0;
  logic msk = 1'h0;
  logic slp = 1'h0;
  logic [3:0] dly = 4'h0;
  logic [31:0] rdat, q;
  logic wreq, ack, req, wake, slpo, crun, cact;
  logic [VEC_W-1:0] vec, tvec;
  logic [VEC_W-1:0] vt [4];
  logic [7:0] tcnt, n0;
  logic [3:0] clr;
  int num_errors = 0;
  int compares = 0;
  int wakes = 0;
  int w0;
  localparam int OP_MSK = 0, OP_UNM = 1, OP_SLP = 2, OP_TAD = 3;

  wic_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .ext_pin_in(ext), .port_pins_in(pins), .tick_ovf_in(tick),
    .conv_done_in(conv), .tad_tick_in(tad), .global_irq_unmask_op_in(unm),
    .global_irq_mask_op_in(msk), .sleep_op_in(slp), .irq_ack_in(ack), .irq_req_out(req),
    .irq_vector_out(vec), .wake_out(wake), .sleep_out(slpo), .clocks_run_out(crun),
    .conv_active_out(cact));

  wic_core_model core_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .irq_req_in(req),
    .irq_vector_in(vec), .ack_dly_in(dly), .irq_ack_out(ack), .taken_vec_out(tvec),
    .taken_cnt_out(tcnt));

  initial
  begin
    forever #2 clk_in = ~clk_in;
  end

  // count wake pulses so a single-cycle pulse is not missed
  always @(posedge clk_in)
    if (wake === 1'h1)
      wakes <= wakes + 1;

  task automatic give_verdict();
    begin
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk_in);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      // hold the request until waitrequest is seen low; the watchdog ends a hang
      do
        @(posedge clk_in);
      while (wreq !== 1'h0);
      q = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    begin
      bus(1'h0, a, 32'h0);
      chk(nm, q, e);
    end
  endtask

  task automatic pulse(input int s);
    begin
      @(posedge clk_in);
      case (s)
        OP_MSK: msk <= 1'h1;
        OP_UNM: unm <= 1'h1;
        OP_SLP: slp <= 1'h1;
        default: tad <= 1'h1;
      endcase
      @(posedge clk_in);
      msk <= 1'h0;
      unm <= 1'h0;
      slp <= 1'h0;
      tad <= 1'h0;
    end
  endtask

  task automatic fire(input int s);
    begin
      @(posedge clk_in);
      case (s)
        0: tick <= 1'h1;
        1: pins <= pins ^ 8'h01;
        2: ext <= 1'h0;
        default: conv <= 1'h1;
      endcase
      @(posedge clk_in);
      tick <= 1'h0;
      conv <= 1'h0;
      repeat (4) @(posedge clk_in);
      ext <= 1'h1;
    end
  endtask

  task automatic cfg(input logic [7:0] m, input logic [7:0] w, input logic [7:0] x);
    begin
      bus(1'h1, ADDR_IRQ_MASK_BANK, {24'h0, m});
      bus(1'h1, ADDR_WAKEUP_CTL_BANK, {24'h0, w});
      bus(1'h1, ADDR_AUX_IRQ_ENABLE_BANK, {24'h0, x});
    end
  endtask

  task automatic do_reset();
    begin
      @(posedge clk_in);
      rst_b_in <= 1'h0;
      pins <= 8'h00;
      repeat (16) @(posedge clk_in);
      rst_b_in <= 1'h1;
    end
  endtask

  initial
  begin
    repeat (30000) @(posedge clk_in);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    rows = '{'{2'h0, 1'h0, 1'h1, VEC_NONE}, '{2'h0, 1'h1, 1'h0, VEC_NONE},
      '{2'h0, 1'h1, 1'h1, VEC_TICK}, '{2'h1, 1'h0, 1'h1, VEC_NONE},
      '{2'h1, 1'h1, 1'h0, VEC_NONE}, '{2'h1, 1'h1, 1'h1, VEC_PIN_CHANGE},
      '{2'h2, 1'h0, 1'h1, VEC_NONE}, '{2'h2, 1'h1, 1'h0, VEC_NONE},
      '{2'h2, 1'h1, 1'h1, VEC_EXT_PIN}, '{2'h3, 1'h0, 1'h1, VEC_NONE},
      '{2'h3, 1'h1, 1'h0, VEC_NONE}, '{2'h3, 1'h1, 1'h1, VEC_CONV_DONE}};
    vt = '{VEC_EXT_PIN, VEC_PIN_CHANGE, VEC_TICK, VEC_CONV_DONE};
    do_reset();
    chk("clocks_run", {31'h0, crun}, 32'h1);
    for (int a = 0; a <= 24; a += 4)
      rchk(8'(a), (8'(a) == ADDR_STATUS) ? 32'h8 : 32'h0, "reset reg");
    bus(1'h1, 8'h18, 32'hFF);
    rchk(8'h18, 32'h0, "unmapped");
    for (int i = 0; i < 12; i++)
    begin
      pulse(OP_MSK);
      cfg((rows[i].src != 2'h3 && rows[i].en) ? 8'h01 << rows[i].src : 8'h00, 8'h00,
        (rows[i].src == 2'h3 && rows[i].en) ? 8'h20 : 8'h00);
      bus(1'h1, ADDR_IRQ_FLAG_BANK, 32'h0);
      if (rows[i].unm)
        pulse(OP_UNM);
      dly <= 4'(i % 3);
      n0 = tcnt;
      fire(rows[i].src);
      repeat (12) @(posedge clk_in);
      rchk(ADDR_IRQ_FLAG_BANK, 32'(rows[i].en) << rows[i].src, "flag");
      chk("vector", 32'((tcnt != n0) ? tvec : VEC_NONE), 32'(rows[i].vec));
    end
    for (int k = 0; k < 3; k++)
    begin
      do_reset();
      cfg((k != 1) ? 8'h02 : 8'h00, (k != 0) ? 8'h02 : 8'h00, 8'h00);
      if (k == 2)
        pulse(OP_UNM);
      pulse(OP_SLP);
      repeat (2) @(posedge clk_in);
      chk("clocks_run", {31'h0, crun}, 32'h0);
      n0 = tcnt;
      w0 = wakes;
      fire(1);
      repeat (10) @(posedge clk_in);
      chk("sleep", {31'h0, slpo}, (k == 0) ? 32'h1 : 32'h0);
      chk("wake", 32'(wakes - w0), (k == 0) ? 32'h0 : 32'h1);
      rchk(ADDR_IRQ_FLAG_BANK, (k != 1) ? 32'h2 : 32'h0, "flag");
      chk("vector", 32'((tcnt != n0) ? tvec : VEC_NONE), (k == 2) ? 32'h6 : 32'h0);
    end
    for (int k = 0; k < 2; k++)
    begin
      do_reset();
      cfg(8'h00, 8'h00, (k == 1) ? 8'h20 : 8'h00);
      bus(1'h1, ADDR_ADC_CTL_WORD, 32'h1);
      pulse(OP_SLP);
      repeat (3) @(posedge clk_in);
      chk("conv_active", {31'h0, cact}, 32'h0);
      chk("clocks_run", {31'h0, crun}, 32'h0);
      rchk(ADDR_IRQ_FLAG_BANK, (k == 1) ? 32'h8 : 32'h0, "flag");
    end
    do_reset();
    cfg(8'h00, 8'h08, 8'h00);
    bus(1'h1, ADDR_ADC_CTL_WORD, 32'h1);
    pulse(OP_SLP);
    repeat (2) @(posedge clk_in);
    chk("clocks_run", {31'h0, crun}, 32'h1);
    w0 = wakes;
    fire(3);
    repeat (14) pulse(OP_TAD);
    chk("sleep", {31'h0, slpo}, 32'h1);
    chk("wake", 32'(wakes - w0), 32'h0);
    pulse(OP_TAD);
    repeat (3) @(posedge clk_in);
    chk("sleep", {31'h0, slpo}, 32'h0);
    chk("wake", 32'(wakes - w0), 32'h1);
    rchk(ADDR_IRQ_FLAG_BANK, 32'h0, "flag");
    do_reset();
    dly <= 4'h3;
    cfg(8'h07, 8'h00, 8'h20);
    for (int s = 0; s < 4; s++)
      fire(s);
    rchk(ADDR_IRQ_FLAG_BANK, 32'hF, "flag");
    clr = 4'hF;
    for (int j = 0; j < 4; j++)
    begin
      n0 = tcnt;
      pulse(OP_UNM);
      repeat (10) @(posedge clk_in);
      chk("vector", 32'((tcnt == n0 + 8'h01) ? tvec : VEC_NONE), 32'(vt[j]));
      clr = clr & ~(4'h1 << ((j == 0) ? 2 : (j == 1) ? 1 : (j == 2) ? 0 : 3));
      bus(1'h1, ADDR_IRQ_FLAG_BANK, {28'h0, clr});
    end
    give_verdict();
  end
endmodule // test_wakeup_interrupt_control
`default_nettype wire

// ### sim/wic_core_model.sv
`default_nettype none
module wic_core_model
  import wic_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic irq_req_in,
  input wire logic [VEC_W-1:0] irq_vector_in,
  input wire logic [3:0] ack_dly_in,
  output logic irq_ack_out,
  output logic [VEC_W-1:0] taken_vec_out,
  output logic [7:0] taken_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  // core takes the vector after a chosen delay
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      irq_ack_out <= 1'h0;
      wait_r <= 4'h0;
      taken_vec_out <= VEC_NONE;
      taken_cnt_out <= 8'h00;
    end
    else if (irq_ack_out || !irq_req_in)
    begin
      irq_ack_out <= 1'h0;
      wait_r <= 4'h0;
    end
    else if (wait_r == ack_dly_in)
    begin
      irq_ack_out <= 1'h1;
      taken_vec_out <= irq_vector_in;
      taken_cnt_out <= taken_cnt_out + 8'h01;
    end
    else
      wait_r <= wait_r + 4'h1;
  end
endmodule // wic_core_model
`default_nettype wire
